// *** rtl/dmac_pkg.sv ***
// package: register map, control word layout and states of the two-channel dma
package dmac_pkg;
	// ------------------------------------------------------------
	// register map (index; byte address is four times the index)
	// ------------------------------------------------------------
	localparam int unsigned WB_ADR_W  = 10;
	localparam int unsigned PTR_W     = 20;
	localparam logic [3:0] CH0_BASE   = 4'hc;
	localparam logic [3:0] CH1_BASE   = 4'hd;
	localparam logic [3:0] FLD_SRC_LO = 4'h0;
	localparam logic [3:0] FLD_SRC_HI = 4'h2;
	localparam logic [3:0] FLD_DST_LO = 4'h4;
	localparam logic [3:0] FLD_DST_HI = 4'h6;
	localparam logic [3:0] FLD_CNT    = 4'h8;
	localparam logic [3:0] FLD_CTL    = 4'ha;
	localparam logic [7:0] OFS_CH0_SOURCE_LOW       = 8'hc0;
	localparam logic [7:0] OFS_CH0_SOURCE_HIGH      = 8'hc2;
	localparam logic [7:0] OFS_CH0_DEST_LOW         = 8'hc4;
	localparam logic [7:0] OFS_CH0_DEST_HIGH        = 8'hc6;
	localparam logic [7:0] OFS_CH0_TRANSFER_COUNTER = 8'hc8;
	localparam logic [7:0] OFS_CH0_CHANNEL_CONTROL  = 8'hca;
	localparam logic [7:0] OFS_CH1_SOURCE_LOW       = 8'hd0;
	localparam logic [7:0] OFS_CH1_SOURCE_HIGH      = 8'hd2;
	localparam logic [7:0] OFS_CH1_DEST_LOW         = 8'hd4;
	localparam logic [7:0] OFS_CH1_DEST_HIGH        = 8'hd6;
	localparam logic [7:0] OFS_CH1_TRANSFER_COUNTER = 8'hd8;
	localparam logic [7:0] OFS_CH1_CHANNEL_CONTROL  = 8'hda;
	// ------------------------------------------------------------
	// channel control word bits
	// ------------------------------------------------------------
	localparam int unsigned CTL_RUN  = 0;
	localparam int unsigned CTL_RWE  = 1;
	localparam int unsigned CTL_TOC  = 2;
	localparam int unsigned CTL_TRE  = 4;
	localparam int unsigned CTL_PRI  = 5;
	localparam int unsigned CTL_SYNC = 6;
	localparam int unsigned CTL_WORD = 8;
	localparam int unsigned CTL_SDN  = 9;
	localparam int unsigned CTL_SUP  = 10;
	localparam int unsigned CTL_SIO  = 11;
	localparam int unsigned CTL_DDN  = 12;
	localparam int unsigned CTL_DUP  = 13;
	localparam int unsigned CTL_DIO  = 14;
	localparam logic [15:0] CTL_STORE_MASK = 16'h7ff5;
	localparam logic [15:0] CTL_RESET      = 16'h0000;
	localparam logic [15:0] REG_RESET      = 16'h0000;
	localparam logic [1:0] SYNC_NONE = 2'h0;
	localparam logic [1:0] SYNC_SRC  = 2'h1;
	localparam logic [1:0] SYNC_DST  = 2'h2;
	localparam logic [1:0] DST_GAP_CLKS = 2'h2;
	localparam logic [PTR_W-1:0] STEP_BYTE = 20'h0_0001;
	localparam logic [PTR_W-1:0] STEP_WORD = 20'h0_0002;

	typedef enum logic [3:0] {
		S_IDLE  = 4'b0001,
		S_FETCH = 4'b0010,
		S_STORE = 4'b0100,
		S_GAP   = 4'b1000
	} dmac_state_t;
endpackage : dmac_pkg

// *** rtl/dmac_top.sv ***
// dmac_top: two-channel dma engine with a classic wishbone register slave
//
// Functional notes
// - each channel moves up to 64K bytes or words, optionally stopping at count.
// - all registers writable while running; new values used on next transfer.
// - priority bit 1 wins over 0; equal priorities alternate transfers.
// - control write changes run flag only with run_write_enable; it reads zero.
// - timer_request_enable gates the timer request; control bit 3 is unused.
// - 20-bit pointer split over low word and four bits of the high word.
// - selected pointer steps by one for bytes, two for words, per transfer.
// - pointer with both step up and step down set stays constant.
// - each pointer picks memory or io space; any value, odd included.
// - counter decrements every transfer; stop at zero only with terminate_on_count.
// - modes are source synced, destination synced and unsynchronized.
// - source synced and unsynced may begin the next transfer immediately.
// - destination synced never prefetches; source read only after request.
// - destination synced releases bus, next cycle two clocks later.
// - dma wins over cpu except locked accesses; hold wins over dma.
// - plain interrupts do not stop dma; nmi blocks new transfers, one in progress completes.
// - cycles only with run flag set; synced modes also need a request.
// - reset clears run flags and abandons any transfer in progress.
// - channel blocks at c0..ca and d0..da in documented order.
// - a transfer is a fetch cycle from source then a store to destination.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/100ps
module dmac_top (
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [dmac_pkg::WB_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                   wb_sel_i,
	input  wire logic [31:0]                  wb_dat_i,
	output logic      [31:0]                  wb_dat_o,
	output logic                              wb_ack_o,
	input  wire logic [1:0]                   channel_request_i,
	input  wire logic                         timer_req_i,
	input  wire logic                         hold_req_i,
	input  wire logic                         nmi_i,
	input  wire logic                         cpu_lock_i,
	output logic                              mbus_cyc_o,
	output logic                              mbus_we_o,
	output logic      [dmac_pkg::PTR_W-1:0]    mbus_adr_o,
	output logic                              mbus_io_o,
	output logic                              mbus_word_o,
	output logic                              mbus_ch_o,
	output logic      [15:0]                  mbus_dat_o,
	input  wire logic [15:0]                  mbus_dat_i,
	input  wire logic                         mbus_ack_i,
	output logic      [1:0]                   run_o
);
	import dmac_pkg::*;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic [15:0] merge16(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] sel);
		merge16 = {sel[1] ? new_v[15:8] : old_v[15:8],
			sel[0] ? new_v[7:0] : old_v[7:0]};
	endfunction : merge16

	function automatic logic [PTR_W-1:0] step_ptr(input logic [PTR_W-1:0] p,
		input logic up, input logic dn, input logic word);
		logic [PTR_W-1:0] amt;
		amt = word ? STEP_WORD : STEP_BYTE;
		if (up && !dn)
			step_ptr = p + amt;
		else if (dn && !up)
			step_ptr = p - amt;
		else
			step_ptr = p;
	endfunction : step_ptr

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [PTR_W-1:0] src_q [2];
	logic [PTR_W-1:0] dst_q [2];
	logic [15:0]      cnt_q [2];
	logic [15:0]      ctl_q [2];
	logic [1:0]       tpend_q;
	logic [3:0]       sy1_q, sy2_q, sy3_q, filt_q;
	dmac_state_t      st_q;
	logic             cur_q, last_q;
	logic [1:0]       gap_q;
	logic [15:0]      data_q;
	logic             wb_ack_q;
	logic [31:0]      wb_dat_q;

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	wire logic [3:0] sy_raw = {nmi_i, hold_req_i, channel_request_i};
	wire logic [3:0] filt_d = (~(sy2_q ^ sy3_q) & sy3_q)
		| ((sy2_q ^ sy3_q) & filt_q);
	wire logic [1:0] req_s  = filt_q[1:0];
	wire logic       hold_s = filt_q[2];
	wire logic       nmi_s  = filt_q[3];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sy1_q  <= 4'h0;
			sy2_q  <= 4'h0;
			sy3_q  <= 4'h0;
			filt_q <= 4'h0;
		end else begin
			sy1_q  <= sy_raw;
			sy2_q  <= sy1_q;
			sy3_q  <= sy2_q;
			filt_q <= filt_d;
		end
	end

	// ------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------
	wire logic [7:0] idx    = wb_adr_i[WB_ADR_W-1:2];
	wire logic       ch_hit = (idx[7:4] == CH0_BASE) || (idx[7:4] == CH1_BASE);
	wire logic       wr_ch  = (idx[7:4] == CH1_BASE);
	wire logic [3:0] fld    = idx[3:0];
	wire logic       acc    = wb_cyc_i && wb_stb_i && !wb_ack_q;
	wire logic       wr_en  = acc && wb_we_i && ch_hit;
	wire logic       wr_slo = wr_en && (fld == FLD_SRC_LO);
	wire logic       wr_shi = wr_en && (fld == FLD_SRC_HI);
	wire logic       wr_dlo = wr_en && (fld == FLD_DST_LO);
	wire logic       wr_dhi = wr_en && (fld == FLD_DST_HI);
	wire logic       wr_cnt = wr_en && (fld == FLD_CNT);
	wire logic       wr_ctl = wr_en && (fld == FLD_CTL);
	wire logic [15:0] wd    = wb_dat_i[15:0];
	wire logic [1:0]  wsel  = wb_sel_i[1:0];
	wire logic [15:0] ctl_mrg = merge16(ctl_q[wr_ch], wd, wsel);

	logic [15:0] rd_val;
	always_comb begin
		rd_val = 16'h0000;
		if (ch_hit) begin
			case (fld)
			FLD_SRC_LO: rd_val = src_q[wr_ch][15:0];
			FLD_SRC_HI: rd_val = {12'h000, src_q[wr_ch][PTR_W-1:16]};
			FLD_DST_LO: rd_val = dst_q[wr_ch][15:0];
			FLD_DST_HI: rd_val = {12'h000, dst_q[wr_ch][PTR_W-1:16]};
			FLD_CNT:    rd_val = cnt_q[wr_ch];
			// enable bit and unused bit 3 read zero
			FLD_CTL:    rd_val = ctl_q[wr_ch] & CTL_STORE_MASK;
			default:    rd_val = 16'h0000;
			endcase
		end
	end

	// unmapped reads answer zero, unmapped writes are dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_q <= 1'b0;
			wb_dat_q <= 32'h0000_0000;
		end else begin
			wb_ack_q <= acc;
			wb_dat_q <= {16'h0000, rd_val};
		end
	end

	// ------------------------------------------------------------
	// channel arbitration
	// ------------------------------------------------------------
	logic [1:0] run, toc, tre, pri, word, elig, req_ok;
	logic [1:0] sync [2];
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			run[c]  = ctl_q[c][CTL_RUN];
			toc[c]  = ctl_q[c][CTL_TOC];
			tre[c]  = ctl_q[c][CTL_TRE];
			pri[c]  = ctl_q[c][CTL_PRI];
			word[c] = ctl_q[c][CTL_WORD];
			sync[c] = ctl_q[c][CTL_SYNC+:2];
			// synced modes need a pending request
			req_ok[c] = (sync[c] != SYNC_SRC && sync[c] != SYNC_DST)
				|| req_s[c] || tpend_q[c];
			// with terminate_on_count a zero count stops the channel
			elig[c] = run[c] && req_ok[c]
				&& !(toc[c] && cnt_q[c] == 16'h0000);
		end
	end

	// higher priority wins, equal priority alternates
	wire logic pick = (elig == 2'b11)
		? ((pri[0] != pri[1]) ? pri[1] : !last_q) : elig[1];
	// hold, nmi and locked cpu accesses keep dma off the bus
	wire logic start = (st_q == S_IDLE) && (elig != 2'b00)
		&& !hold_s && !nmi_s && !cpu_lock_i;
	wire logic done  = (st_q == S_STORE) && mbus_ack_i;
	wire logic cur_dst_sync = (sync[cur_q] == SYNC_DST);

	// ------------------------------------------------------------
	// channel registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < 2; c++) begin
				src_q[c] <= {4'h0, REG_RESET};
				dst_q[c] <= {4'h0, REG_RESET};
				cnt_q[c] <= REG_RESET;
				ctl_q[c] <= CTL_RESET;
			end
			tpend_q <= 2'b00;
		end else begin
			for (int c = 0; c < 2; c++) begin
				// timer request gated; set wins over clear
				tpend_q[c] <= (timer_req_i && tre[c])
					|| (tpend_q[c] && !(start && pick == c));
				if (done && cur_q == c) begin
					src_q[c] <= step_ptr(src_q[c], ctl_q[c][CTL_SUP],
						ctl_q[c][CTL_SDN], word[c]);
					dst_q[c] <= step_ptr(dst_q[c], ctl_q[c][CTL_DUP],
						ctl_q[c][CTL_DDN], word[c]);
					cnt_q[c] <= cnt_q[c] - 16'h0001;
					if (toc[c] && cnt_q[c] == 16'h0001)
						ctl_q[c][CTL_RUN] <= 1'b0;
				end
				// software writes override in the same cycle
				if (wr_ch == c) begin
					if (wr_slo)
						src_q[c][15:0] <= merge16(src_q[c][15:0], wd, wsel);
					if (wr_shi && wsel[0])
						src_q[c][PTR_W-1:16] <= wd[3:0];
					if (wr_dlo)
						dst_q[c][15:0] <= merge16(dst_q[c][15:0], wd, wsel);
					if (wr_dhi && wsel[0])
						dst_q[c][PTR_W-1:16] <= wd[3:0];
					if (wr_cnt)
						cnt_q[c] <= merge16(cnt_q[c], wd, wsel);
					if (wr_ctl) begin
						ctl_q[c][15:1] <= ctl_mrg[15:1]
							& CTL_STORE_MASK[15:1];
						// run flag only follows with run_write_enable
						if (wsel[0] && wd[CTL_RWE])
							ctl_q[c][CTL_RUN] <= wd[CTL_RUN];
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// transfer sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q        <= S_IDLE;
			cur_q       <= 1'b0;
			last_q      <= 1'b1;
			gap_q       <= 2'h0;
			data_q      <= 16'h0000;
			mbus_cyc_o  <= 1'b0;
			mbus_we_o   <= 1'b0;
			mbus_adr_o  <= {4'h0, REG_RESET};
			mbus_io_o   <= 1'b0;
			mbus_word_o <= 1'b0;
			mbus_ch_o   <= 1'b0;
		end else begin
			case (st_q)
			S_IDLE: begin
				if (start) begin
					cur_q       <= pick;
					last_q      <= pick;
					mbus_ch_o   <= pick;
					mbus_cyc_o  <= 1'b1;
					mbus_we_o   <= 1'b0;
					mbus_adr_o  <= src_q[pick];
					mbus_io_o   <= ctl_q[pick][CTL_SIO];
					mbus_word_o <= word[pick];
					st_q        <= S_FETCH;
				end
			end
			S_FETCH: begin
				if (mbus_ack_i) begin
					data_q      <= mbus_dat_i;
					mbus_we_o   <= 1'b1;
					mbus_adr_o  <= dst_q[cur_q];
					mbus_io_o   <= ctl_q[cur_q][CTL_DIO];
					st_q        <= S_STORE;
				end
			end
			S_STORE: begin
				if (mbus_ack_i) begin
					mbus_cyc_o <= 1'b0;
					mbus_we_o  <= 1'b0;
					// destination synced lets the bus go for a gap
					if (cur_dst_sync) begin
						gap_q <= DST_GAP_CLKS - 2'h2;
						st_q  <= S_GAP;
					end else begin
						// back to idle, next transfer may start at once
						st_q <= S_IDLE;
					end
				end
			end
			S_GAP: begin
				if (gap_q == 2'h0)
					st_q <= S_IDLE;
				else
					gap_q <= gap_q - 2'h1;
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end

	assign mbus_dat_o = data_q;
	assign wb_ack_o   = wb_ack_q;
	assign wb_dat_o   = wb_dat_q;
	assign run_o      = run;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	wire logic [15:0]      cnt_cur = cnt_q[cur_q];
	wire logic [PTR_W-1:0] src_cur = src_q[cur_q];
	wire logic cur_sup = ctl_q[cur_q][CTL_SUP];
	wire logic cur_sdn = ctl_q[cur_q][CTL_SDN];

	property p_reset_stops;
		@(posedge clk_i) rst_i |=> (run == 2'b00) && !mbus_cyc_o;
	endproperty
	a_reset_stops: assert property (p_reset_stops)
		else $error("reset left a channel running");

	property p_count_dec;
		@(posedge clk_i) disable iff (rst_i)
		(done && !wr_en) |=> cnt_cur == $past(cnt_cur) - 16'h0001;
	endproperty
	a_count_dec: assert property (p_count_dec)
		else $error("counter did not decrement by one");

	property p_toc_stop;
		@(posedge clk_i) disable iff (rst_i)
		(done && !wr_en && toc[cur_q] && cnt_cur == 16'h0001)
			|=> !run[cur_q] && !elig[cur_q];
	endproperty
	a_toc_stop: assert property (p_toc_stop)
		else $error("channel kept running at zero count");

	property p_ptr_hold;
		@(posedge clk_i) disable iff (rst_i)
		(done && !wr_en && cur_sup && cur_sdn) |=> src_cur == $past(src_cur);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold)
		else $error("pointer moved with both directions set");

	property p_word_step;
		@(posedge clk_i) disable iff (rst_i)
		(done && !wr_en && cur_sup && !cur_sdn && word[cur_q])
			|=> src_cur == $past(src_cur) + STEP_WORD;
	endproperty
	a_word_step: assert property (p_word_step)
		else $error("word transfer did not step pointer by two");

	property p_dst_gap;
		@(posedge clk_i) disable iff (rst_i)
		(done && cur_dst_sync) |=> !mbus_cyc_o [*2];
	endproperty
	a_dst_gap: assert property (p_dst_gap)
		else $error("destination synced transfer skipped the bus gap");

	property p_dst_no_prefetch;
		@(posedge clk_i) disable iff (rst_i)
		($rose(mbus_cyc_o) && cur_dst_sync)
			|-> (mbus_ch_o ? $past(req_s[1] || tpend_q[1])
				: $past(req_s[0] || tpend_q[0]));
	endproperty
	a_dst_no_prefetch: assert property (p_dst_no_prefetch)
		else $error("destination synced fetch without a request");

	property p_hold_wins;
		@(posedge clk_i) disable iff (rst_i)
		(st_q == S_IDLE && hold_s) |=> !mbus_cyc_o;
	endproperty
	a_hold_wins: assert property (p_hold_wins)
		else $error("dma started against a hold request");

	property p_nmi_halts;
		@(posedge clk_i) disable iff (rst_i)
		(st_q == S_IDLE && nmi_s) |=> !mbus_cyc_o;
	endproperty
	a_nmi_halts: assert property (p_nmi_halts)
		else $error("dma started while nmi pending");

	property p_run_needed;
		@(posedge clk_i) disable iff (rst_i)
		$rose(mbus_cyc_o)
			|-> (mbus_ch_o ? $past(run[1]) : $past(run[0]));
	endproperty
	a_run_needed: assert property (p_run_needed)
		else $error("fetch on a stopped channel");
endmodule : dmac_top

// *** tb/dmac_mem.sv ***
// dmac_mem: memory and io model answering the dma bus
`timescale 1ns/100ps
module dmac_mem (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        we_i,
	input  wire logic [19:0] adr_i,
	input  wire logic        io_i,
	input  wire logic        word_i,
	input  wire logic        ch_i,
	input  wire logic [15:0] dat_i,
	input  wire logic [1:0]  lat_i,
	output logic             ack_o,
	output logic      [15:0] dat_o
);
	logic [1:0]  wait_q;
	logic [19:0] fa_q;
	logic [19:0] sa_q;
	logic [15:0] sd_q;
	logic        io_q;
	logic        word_q;
	logic [3:0]  seq_q;
	int          fetches = 0;
	int          stores = 0;
	// ------------------------------------------------------------
	// bus answer
	// ------------------------------------------------------------
	// access is its own acknowledge
	always_ff @(posedge clk_i) begin
		// released data lines keep changing so stale data never matches
		dat_o <= ~dat_o;
		if (rst_i) begin
			ack_o  <= 1'b0;
			wait_q <= 2'h0;
			dat_o  <= 16'h0000;
		end else if (cyc_i && !ack_o && wait_q < lat_i) begin
			wait_q <= wait_q + 2'h1;
		end else if (cyc_i && !ack_o) begin
			ack_o  <= 1'b1;
			wait_q <= 2'h0;
			if (we_i) begin
				stores <= stores + 1;
				sa_q   <= adr_i;
				sd_q   <= dat_i;
				io_q   <= io_i;
				word_q <= word_i;
				seq_q  <= {seq_q[2:0], ch_i};
			end else begin
				fetches <= fetches + 1;
				fa_q    <= adr_i;
				dat_o   <= adr_i[15:0] ^ 16'h3c3c;
			end
		end else begin
			ack_o <= 1'b0;
		end
	end
endmodule : dmac_mem

// *** tb/dmac_top_bench.sv ***
// dmac_top_bench: register-level tests of the two-channel dma
`timescale 1ns/100ps
module dmac_top_bench;
	import dmac_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [9:0]  adr = 10'h000;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic        ack;
	logic [1:0]  creq = 2'h0;
	logic        treq = 1'b0;
	logic        hold = 1'b0;
	logic        nmi = 1'b0;
	logic        lock = 1'b0;
	logic [1:0]  lat = 2'h0;
	logic        m_cyc, m_we, m_io, m_word, m_ch, m_ack;
	logic [19:0] m_adr;
	logic [15:0] m_dout, m_din;
	logic [1:0]  run;
	int          mismatches = 0;
	int          checks = 0;
	int          s0, f0, i;

	always #5 clk_i = ~clk_i;

	dmac_top dmac_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.channel_request_i(creq), .timer_req_i(treq), .hold_req_i(hold),
		.nmi_i(nmi), .cpu_lock_i(lock), .mbus_cyc_o(m_cyc),
		.mbus_we_o(m_we), .mbus_adr_o(m_adr), .mbus_io_o(m_io),
		.mbus_word_o(m_word), .mbus_ch_o(m_ch), .mbus_dat_o(m_dout),
		.mbus_dat_i(m_din), .mbus_ack_i(m_ack), .run_o(run));

	dmac_mem dmac_mem_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(m_cyc),
		.we_i(m_we), .adr_i(m_adr), .io_i(m_io), .word_i(m_word),
		.ch_i(m_ch), .dat_i(m_dout), .lat_i(lat), .ack_o(m_ack),
		.dat_o(m_din));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic wrap_up();
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic pause(input int n);
		repeat (n) @(posedge clk_i);
	endtask : pause

	// one classic cycle; waits for ack under a bound
	task automatic wb(input logic w, input logic [7:0] ofs,
		input logic [15:0] d, output logic [15:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc  <= 1'b1;
		we   <= w;
		adr  <= {ofs, 2'b00};
		wdat <= {16'h0000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat[15:0];
		cyc <= 1'b0;
		if (n >= 50) begin
			mismatches++;
			wrap_up();
		end
	endtask : wb

	task automatic wr(input logic [7:0] ofs, input logic [15:0] d);
		logic [15:0] q;
		wb(1'b1, ofs, d, q);
	endtask : wr

	task automatic rc(input string nm, input logic [7:0] ofs,
		input logic [15:0] exp);
		logic [15:0] q;
		wb(1'b0, ofs, 16'h0000, q);
		chk(nm, {16'h0000, q}, {16'h0000, exp});
	endtask : rc

	task automatic cfg(input logic ch, input logic [19:0] src,
		input logic [19:0] dst, input logic [15:0] cnt,
		input logic [15:0] ctl);
		logic [7:0] b;
		b = ch ? OFS_CH1_SOURCE_LOW : OFS_CH0_SOURCE_LOW;
		s0 = dmac_mem_i.stores;
		f0 = dmac_mem_i.fetches;
		wr(b, src[15:0]);
		wr(b + 8'h02, {12'h000, src[19:16]});
		wr(b + 8'h04, dst[15:0]);
		wr(b + 8'h06, {12'h000, dst[19:16]});
		wr(b + 8'h08, cnt);
		wr(b + 8'h0a, ctl);
	endtask : cfg

	task automatic idle(input int ch);
		int n;
		n = 0;
		while (run[ch] !== 1'b0 && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 3000) begin
			mismatches++;
			wrap_up();
		end
	endtask : idle

	function automatic logic [31:0] ds();
		return dmac_mem_i.stores - s0;
	endfunction : ds

	function automatic logic [31:0] df();
		return dmac_mem_i.fetches - f0;
	endfunction : df

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		pause(60000);
		mismatches++;
		wrap_up();
	end

	initial begin
		pause(12);
		rst_i <= 1'b0;
		pause(4);
		chk("run_rst", run, 0);
		rc("ctl0_rst", OFS_CH0_CHANNEL_CONTROL, 16'h0000);
		rc("cnt1_rst", OFS_CH1_TRANSFER_COUNTER, 16'h0000);
		wr(8'hcc, 16'hffff);
		rc("unmapped", 8'hcc, 16'h0000);
		wr(OFS_CH0_CHANNEL_CONTROL, 16'h0005);
		chk("run_no_rwe", run, 0);
		rc("ctl0_rb", OFS_CH0_CHANNEL_CONTROL, 16'h0004);
		// byte, both pointers up, destination in io space
		cfg(1'b0, 20'h1_2340, 20'h5_0000, 16'h0003, 16'h6407);
		idle(0);
		chk("stores3", ds(), 3);
		chk("last_dst", dmac_mem_i.sa_q, 20'h5_0002);
		chk("last_src", dmac_mem_i.fa_q, 20'h1_2342);
		chk("dst_io", dmac_mem_i.io_q, 1);
		rc("cnt0_end", OFS_CH0_TRANSFER_COUNTER, 16'h0000);
		rc("src0_lo", OFS_CH0_SOURCE_LOW, 16'h2343);
		rc("ctl0_end", OFS_CH0_CHANNEL_CONTROL, 16'h6404);
		// word, source held, destination down, odd addresses, slow bus
		lat <= 2'h3;
		cfg(1'b1, 20'h0_0101, 20'h0_0203, 16'h0002, 16'h1707);
		idle(1);
		chk("stores2", ds(), 2);
		chk("src_held", dmac_mem_i.fa_q, 20'h0_0101);
		chk("dst_down", dmac_mem_i.sa_q, 20'h0_0201);
		chk("data", dmac_mem_i.sd_q, 16'h3d3d);
		chk("word", dmac_mem_i.word_q, 1);
		rc("dst1_lo", OFS_CH1_DEST_LOW, 16'h01ff);
		// count runs through zero without terminate_on_count
		lat <= 2'h0;
		cfg(1'b0, 20'h0_0000, 20'h0_0010, 16'h0002, 16'h0003);
		pause(60);
		wr(OFS_CH0_CHANNEL_CONTROL, 16'h0002);
		pause(20);
		chk("run_stop", run, 0);
		rc("cnt_wrap", OFS_CH0_TRANSFER_COUNTER, 16'h0002 - ds());
		// hold, nmi and locked cycles each hold off new transfers
		for (i = 0; i < 3; i++) begin
			{lock, nmi, hold} <= 3'(1 << i);
			pause(8);
			cfg(1'b0, 20'h0_0020, 20'h0_0030, 16'h0001, 16'h0007);
			pause(40);
			chk("gated", df(), 0);
			{lock, nmi, hold} <= 3'h0;
			idle(0);
			chk("ungated", ds(), 1);
		end
		// destination synchronized waits for its request
		cfg(1'b0, 20'h0_0400, 20'h0_0500, 16'h0002, 16'h0087);
		pause(30);
		chk("no_prefetch", df(), 0);
		creq <= 2'h1;
		idle(0);
		creq <= 2'h0;
		chk("dst_sync", ds(), 2);
		// timer requests only count when enabled
		cfg(1'b1, 20'h0_0600, 20'h0_0700, 16'h0001, 16'h0047);
		@(posedge clk_i);
		treq <= 1'b1;
		@(posedge clk_i);
		treq <= 1'b0;
		pause(20);
		chk("tmr_off", df(), 0);
		wr(OFS_CH1_CHANNEL_CONTROL, 16'h0057);
		treq <= 1'b1;
		@(posedge clk_i);
		treq <= 1'b0;
		idle(1);
		chk("tmr_on", ds(), 1);
		// high priority channel 1 goes first when both are ready
		// hold keeps transfers off between register updates
		hold <= 1'b1;
		pause(8);
		cfg(1'b0, 20'h0_0800, 20'h0_0900, 16'h0002, 16'h0007);
		cfg(1'b1, 20'h0_0a00, 20'h0_0b00, 16'h0002, 16'h0027);
		hold <= 1'b0;
		idle(0);
		idle(1);
		chk("prio", dmac_mem_i.seq_q, 4'b1100);
		// reset in mid-run abandons everything
		cfg(1'b0, 20'h0_0c00, 20'h0_0d00, 16'h0005, 16'h0003);
		pause(7);
		rst_i <= 1'b1;
		pause(2);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("run_abort", run, 0);
		chk("cyc_abort", m_cyc, 0);
		rc("ctl_abort", OFS_CH0_CHANNEL_CONTROL, 16'h0000);
		wrap_up();
	end
endmodule : dmac_top_bench
